// file: rlcr_regs.sv
`default_nettype none
module rlcr_regs #(
    parameter logic [4:0]  ADDR_HI_LOW   = 5'h05,
    parameter logic [4:0]  ADDR_HI_RES   = 5'h06,
    parameter logic [4:0]  ADDR_HI_FLOAT = 5'h04,
    parameter logic [4:0]  ADDR_HI_HIGH  = 5'h03,
    parameter logic [13:0] DEBOUNCE_CYC  = 14'(rlcr_pkg::DEBOUNCE_CYC),
    parameter logic [22:0] RXDET_CYC_0   = 23'(rlcr_pkg::RXDET_CYC_0),
    parameter logic [22:0] RXDET_CYC_1   = 23'(rlcr_pkg::RXDET_CYC_1),
    parameter logic [22:0] RXDET_CYC_2   = 23'(rlcr_pkg::RXDET_CYC_2),
    parameter logic [22:0] RXDET_CYC_3   = 23'(rlcr_pkg::RXDET_CYC_3)
) (
    input  wire logic                 core_clk,                // 50 MHz
    input  wire logic                 rst_n,                   // async, active low
    input  wire logic                 scl_in,                  // i2c clock level
    input  wire logic                 sda_in,                  // i2c data level
    output logic                      sda_out,                 // i2c data drive value
    output logic                      sda_oe_n,                // low while pulling sda
    input  wire logic [1:0]           target_addr_strap_high,  // strap level code
    input  wire logic [1:0]           target_addr_strap_low,   // strap level code
    input  wire logic [3:0]           downstream_gain_straps,  // two pin level codes
    input  wire logic [3:0]           upstream_gain_straps,    // two pin level codes
    input  wire logic                 low_power_in,            // link in u2 or u3
    input  wire logic                 lfps_in,                 // lfps being received
    input  wire logic                 fsm_compliance_in,       // internal fsm wants compliance
    output rlcr_pkg::rlcr_gain_t      gain_out,                // gain applied to receivers
    output logic                      low_power_exit_ok,       // lfps qualified for exit
    output logic                      rxdet_req,               // detect pulse
    output logic                      compliance_force_ds,     // force downstream compliance
    output logic                      compliance_force_us,     // force upstream compliance
    output logic                      compliance_block,        // compliance disabled
    output logic                      flip_sel,                // general flip select
    output logic [1:0]                ctl_sel                  // general control select
);
    import rlcr_pkg::*;

    rlcr_state_t st_ff;
    logic        scl_q_ff, sda_q_ff, rw_ff, nack_ff;
    logic [3:0]  cnt_ff;
    logic [7:0]  sh_ff, ptr_ff;
    logic        wr_stb_ff;
    logic [7:0]  wr_addr_ff, wr_data_ff;
    logic [7:0]  gen_ff, ds_ff;
    logic [3:0]  us_ff;
    logic [6:0]  lnk_ff;
    logic        cm_ff;
    logic [13:0] deb_cnt_ff;
    logic [22:0] rx_cnt_ff;
    logic        oe_n_ff, exit_ff, rxreq_ff;
    rlcr_gain_t  gain_ff;

    wire scl_rise  = scl_in & ~scl_q_ff;
    wire scl_fall  = ~scl_in & scl_q_ff;
    wire start_det = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
    wire stop_det  = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
    wire byte_done = scl_fall & (cnt_ff == 4'h8);

    logic [4:0] addr_hi;
    always_comb begin
        case (target_addr_strap_high)
            LVL_LOW:   addr_hi = ADDR_HI_LOW;
            LVL_RES:   addr_hi = ADDR_HI_RES;
            LVL_FLOAT: addr_hi = ADDR_HI_FLOAT;
            default:   addr_hi = ADDR_HI_HIGH;
        endcase
    end
    wire [6:0] my_addr    = {addr_hi, target_addr_strap_low};
    wire       addr_match = (sh_ff[7:1] == my_addr);

    wire ovr = gen_ff[GEN_OVR_BIT];
    wire [7:0] lnk_rd = {cm_ff, lnk_ff};
    wire [7:0] rd_data = (ptr_ff == OFS_GENERAL)  ? {3'h0, gen_ff[4], 1'b0, gen_ff[2:0]} :
                         (ptr_ff == OFS_DS_EQ)    ? ds_ff :
                         (ptr_ff == OFS_US_EQ)    ? {4'h0, us_ff} :
                         (ptr_ff == OFS_LINK_CTL) ? lnk_rd : 8'h00;
    wire load_rd = (st_ff == RLCR_AACK && scl_fall && rw_ff) ||
                   (st_ff == RLCR_RACK && scl_fall && !nack_ff);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff      <= RLCR_IDLE;
            scl_q_ff   <= 1'b1;
            sda_q_ff   <= 1'b1;
            rw_ff      <= 1'b0;
            nack_ff    <= 1'b1;
            cnt_ff     <= 4'h0;
            sh_ff      <= 8'h00;
            ptr_ff     <= 8'h00;
            oe_n_ff    <= 1'b1;
            wr_stb_ff  <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end else begin
            scl_q_ff  <= scl_in;
            sda_q_ff  <= sda_in;
            wr_stb_ff <= 1'b0;
            if (stop_det) begin
                st_ff   <= RLCR_IDLE;
                oe_n_ff <= 1'b1;
            end else if (start_det) begin
                st_ff   <= RLCR_ADDR;
                cnt_ff  <= 4'h0;
                oe_n_ff <= 1'b1;
            end else if (load_rd) begin
                sh_ff   <= rd_data;
                oe_n_ff <= rd_data[7];
                ptr_ff  <= ptr_ff + 8'h01;
                cnt_ff  <= 4'h1;
                st_ff   <= RLCR_RDAT;
            end else begin
                case (st_ff)
                    RLCR_ADDR, RLCR_SUB, RLCR_WDAT: begin
                        if (scl_rise) begin
                            sh_ff  <= {sh_ff[6:0], sda_in};
                            cnt_ff <= cnt_ff + 4'h1;
                        end else if (byte_done) begin
                            cnt_ff <= 4'h0;
                            if (st_ff == RLCR_ADDR) begin
                                oe_n_ff <= ~addr_match;
                                rw_ff   <= sh_ff[0];
                                st_ff   <= addr_match ? RLCR_AACK : RLCR_IDLE;
                            end else if (st_ff == RLCR_SUB) begin
                                ptr_ff  <= sh_ff;
                                oe_n_ff <= 1'b0;
                                st_ff   <= RLCR_SACK;
                            end else begin
                                wr_stb_ff  <= 1'b1;
                                wr_addr_ff <= ptr_ff;
                                wr_data_ff <= sh_ff;
                                ptr_ff     <= ptr_ff + 8'h01;
                                oe_n_ff    <= 1'b0;
                                st_ff      <= RLCR_WACK;
                            end
                        end
                    end
                    RLCR_AACK: begin
                        if (scl_fall) begin
                            oe_n_ff <= 1'b1;
                            st_ff   <= RLCR_SUB;
                        end
                    end
                    RLCR_SACK, RLCR_WACK: begin
                        if (scl_fall) begin
                            oe_n_ff <= 1'b1;
                            st_ff   <= RLCR_WDAT;
                        end
                    end
                    RLCR_RDAT: begin
                        if (byte_done) begin
                            oe_n_ff <= 1'b1;
                            st_ff   <= RLCR_RACK;
                        end else if (scl_fall) begin
                            oe_n_ff <= sh_ff[6];
                            sh_ff   <= {sh_ff[6:0], 1'b0};
                            cnt_ff  <= cnt_ff + 4'h1;
                        end
                    end
                    RLCR_RACK: begin
                        if (scl_rise) begin
                            nack_ff <= sda_in;
                        end else if (scl_fall) begin
                            st_ff <= RLCR_IDLE;
                        end
                    end
                    default: st_ff <= RLCR_IDLE;
                endcase
            end
        end
    end

    // register file
    wire wr_gen = wr_stb_ff && (wr_addr_ff == OFS_GENERAL);
    wire wr_ds  = wr_stb_ff && (wr_addr_ff == OFS_DS_EQ);
    wire wr_us  = wr_stb_ff && (wr_addr_ff == OFS_US_EQ);
    wire wr_lnk = wr_stb_ff && (wr_addr_ff == OFS_LINK_CTL);

    // strap refresh beats software writes while override is clear
    wire [7:0] nxt_ds  = !ovr ? {downstream_gain_straps, downstream_gain_straps} :
                         wr_ds ? wr_data_ff : ds_ff;
    wire [3:0] nxt_us  = !ovr ? upstream_gain_straps :
                         wr_us ? wr_data_ff[3:0] : us_ff;
    wire [1:0] cmc     = lnk_ff[1:0];
    wire nxt_cm = (cmc == CMC_FORCE_DS) || (cmc == CMC_FORCE_US) ||
                  ((cmc == CMC_AUTO) && fsm_compliance_in);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_ff <= RST_GENERAL;
            ds_ff  <= RST_DS_EQ;
            us_ff  <= RST_US_EQ;
            lnk_ff <= RST_LINK_CTL;
            cm_ff  <= 1'b0;
        end else begin
            if (wr_gen) begin
                gen_ff <= {3'h0, wr_data_ff[4], 1'b0, wr_data_ff[2:0]};
            end
            if (wr_lnk) begin
                lnk_ff <= wr_data_ff[6:0];
            end
            ds_ff <= nxt_ds;
            us_ff <= nxt_us;
            cm_ff <= nxt_cm;
        end
    end

    // receiver gain, lfps debounce and detect timing
    wire       lfps_apply = lnk_ff[LNK_LFPS_BIT];
    wire       deb_en     = lnk_ff[LNK_DEB_BIT];
    wire       rx_off     = low_power_in & lnk_ff[LNK_RXDIS_BIT];
    wire [1:0] int_sel    = lnk_ff[LNK_INT_LSB +: 2];
    wire [22:0] rx_limit  = (int_sel == 2'h0) ? RXDET_CYC_0 :
                            (int_sel == 2'h1) ? RXDET_CYC_1 :
                            (int_sel == 2'h2) ? RXDET_CYC_2 : RXDET_CYC_3;
    wire        rx_hit    = (rx_cnt_ff >= rx_limit - 23'h1);
    wire        lfps_lp   = lfps_in & low_power_in;
    wire        deb_done  = (deb_cnt_ff >= DEBOUNCE_CYC - 14'h1);
    wire        zero_gain = lfps_in & ~lfps_apply;
    wire [13:0] nxt_deb   = !lfps_lp ? 14'h0 : deb_done ? deb_cnt_ff : deb_cnt_ff + 14'h1;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_ff    <= '0;
            deb_cnt_ff <= 14'h0;
            exit_ff    <= 1'b0;
            rx_cnt_ff  <= 23'h0;
            rxreq_ff   <= 1'b0;
        end else begin
            gain_ff    <= zero_gain ? '0 : {ds_ff, us_ff};
            deb_cnt_ff <= nxt_deb;
            exit_ff    <= lfps_lp & (~deb_en | deb_done);
            rx_cnt_ff  <= (rx_off | rx_hit) ? 23'h0 : rx_cnt_ff + 23'h1;
            rxreq_ff   <= ~rx_off & rx_hit;
        end
    end

    assign sda_out             = 1'b0;
    assign sda_oe_n            = oe_n_ff;
    assign gain_out            = gain_ff;
    assign low_power_exit_ok   = exit_ff;
    assign rxdet_req           = rxreq_ff;
    assign compliance_force_ds = (cmc == CMC_FORCE_DS);
    assign compliance_force_us = (cmc == CMC_FORCE_US);
    assign compliance_block    = (cmc == CMC_DISABLE);
    assign flip_sel            = gen_ff[GEN_FLIP_BIT];
    assign ctl_sel             = gen_ff[1:0];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_lp_lfps_start;
        deb_en && lfps_lp && (deb_cnt_ff == 14'h0);
    endsequence

    a_strap_ds_load: assert property (!ovr |=> ds_ff == {2{$past(downstream_gain_straps)}})
        else $error("downstream gain not loaded from straps");
    a_strap_us_load: assert property (!ovr |=> us_ff == $past(upstream_gain_straps))
        else $error("upstream gain not loaded from straps");
    a_ovr_write_ds: assert property (ovr && wr_ds |=> ds_ff == $past(wr_data_ff))
        else $error("override write not applied");
    a_ovr_hold_us: assert property (ovr && !wr_us |=> $stable(us_ff))
        else $error("upstream gain changed without write");
    a_us_rsvd_zero: assert property (ptr_ff == OFS_US_EQ |-> rd_data[7:4] == 4'h0)
        else $error("upstream reserved bits not zero");
    a_cm_disabled: assert property (cmc == CMC_DISABLE |=> !cm_ff)
        else $error("compliance status set while disabled");
    a_lfps_zero_gain: assert property (lfps_in && !lfps_apply |=> gain_out == '0)
        else $error("gain not zero during lfps");
    a_nodeb_exit: assert property (!deb_en && lfps_lp |=> low_power_exit_ok)
        else $error("exit not immediate without debounce");
    a_deb_wait: assert property (s_lp_lfps_start |=> !low_power_exit_ok [*2])
        else $error("exit before debounce elapsed");
    a_rxdet_off: assert property (rx_off |=> !rxdet_req)
        else $error("detect issued while suppressed");
    a_addr_nack: assert property (st_ff == RLCR_ADDR && byte_done && !addr_match
                                  |=> st_ff == RLCR_IDLE && sda_oe_n)
        else $error("foreign address acknowledged");
    a_ptr_advance: assert property (load_rd && !stop_det && !start_det
                                    |=> ptr_ff == $past(ptr_ff) + 8'h01)
        else $error("read pointer did not advance");

    sequence s_detect_fire;
        rxdet_req;
    endsequence

    a_ovr_write_us: assert property (ovr && wr_us |=> us_ff == $past(wr_data_ff[3:0]))
        else $error("upstream override write not applied");
    a_ovr_hold_ds: assert property (ovr && !wr_ds |=> $stable(ds_ff))
        else $error("downstream gain changed without write");
    a_strap_wins: assert property (!ovr && wr_ds |=> ds_ff == {2{$past(downstream_gain_straps)}})
        else $error("software write kept while override clear");
    a_cm_forced: assert property (cmc == CMC_FORCE_DS || cmc == CMC_FORCE_US |=> cm_ff)
        else $error("compliance status clear while forced");
    a_cm_auto: assert property (cmc == CMC_AUTO |=> cm_ff == $past(fsm_compliance_in))
        else $error("compliance status not following internal request");
    a_gain_follow: assert property (!lfps_in || lfps_apply |=> gain_out == {$past(ds_ff), $past(us_ff)})
        else $error("programmed gain not applied");
    a_exit_needs_lfps: assert property (low_power_exit_ok |-> $past(lfps_lp))
        else $error("exit without lfps in low power");
    a_detect_pulse: assert property (s_detect_fire |=> !rxdet_req [*8])
        else $error("detect pulses too close");
    a_ack_driven: assert property (st_ff == RLCR_AACK || st_ff == RLCR_SACK || st_ff == RLCR_WACK
                                   |-> !sda_oe_n)
        else $error("acknowledge not driven");
    a_rd_msb_first: assert property (load_rd |=> sda_oe_n == $past(rd_data[7]))
        else $error("read byte not started with msb");
endmodule
`default_nettype wire

// file: rlcr_pkg.sv
`default_nettype none
package rlcr_pkg;
    localparam logic [7:0] OFS_GENERAL    = 8'h0a;
    localparam logic [7:0] OFS_DS_EQ      = 8'h20;
    localparam logic [7:0] OFS_US_EQ      = 8'h21;
    localparam logic [7:0] OFS_LINK_CTL   = 8'h22;
    localparam logic [7:0] RST_GENERAL    = 8'h01;
    localparam logic [7:0] RST_DS_EQ      = 8'h00;
    localparam logic [3:0] RST_US_EQ      = 4'h0;
    localparam logic [6:0] RST_LINK_CTL   = 7'h04;
    localparam int         GEN_OVR_BIT    = 4;
    localparam int         GEN_FLIP_BIT   = 2;
    localparam int         LNK_CM_BIT     = 7;
    localparam int         LNK_LFPS_BIT   = 6;
    localparam int         LNK_DEB_BIT    = 5;
    localparam int         LNK_RXDIS_BIT  = 4;
    localparam int         LNK_INT_LSB    = 2;
    localparam logic [1:0] CMC_AUTO       = 2'h0;
    localparam logic [1:0] CMC_FORCE_DS   = 2'h1;
    localparam logic [1:0] CMC_FORCE_US   = 2'h2;
    localparam logic [1:0] CMC_DISABLE    = 2'h3;
    localparam logic [1:0] LVL_LOW        = 2'h0;
    localparam logic [1:0] LVL_RES        = 2'h1;
    localparam logic [1:0] LVL_FLOAT      = 2'h2;
    localparam logic [1:0] LVL_HIGH       = 2'h3;
    localparam int         CLK_MHZ        = 50;
    localparam int         DEBOUNCE_US    = 200;
    localparam int         DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
    localparam int         RXDET_MS_0     = 8;
    localparam int         RXDET_MS_1     = 12;
    localparam int         RXDET_MS_2     = 48;
    localparam int         RXDET_MS_3     = 96;
    localparam int         RXDET_CYC_0    = RXDET_MS_0 * CLK_MHZ * 1000;
    localparam int         RXDET_CYC_1    = RXDET_MS_1 * CLK_MHZ * 1000;
    localparam int         RXDET_CYC_2    = RXDET_MS_2 * CLK_MHZ * 1000;
    localparam int         RXDET_CYC_3    = RXDET_MS_3 * CLK_MHZ * 1000;
    typedef enum logic [3:0] {
        RLCR_IDLE = 4'h0,
        RLCR_ADDR = 4'h1,
        RLCR_AACK = 4'h2,
        RLCR_SUB  = 4'h3,
        RLCR_SACK = 4'h4,
        RLCR_WDAT = 4'h5,
        RLCR_WACK = 4'h6,
        RLCR_RDAT = 4'h7,
        RLCR_RACK = 4'h8
    } rlcr_state_t;
    typedef struct packed {
        logic [3:0] second_downstream_gain_select;
        logic [3:0] first_downstream_gain_select;
        logic [3:0] upstream_gain_select;
    } rlcr_gain_t;
endpackage
`default_nettype wire

// file: rlcr_i2c_ctl.sv
`default_nettype none
module rlcr_i2c_ctl (
    input  wire logic core_clk,  // system clock
    input  wire logic sda_line,  // resolved data wire
    output var  logic scl,       // clock drive
    output var  logic sda_rel    // high releases data wire
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // each phase is four clocks; bit sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        hold(2);
        sda_rel = b;
        hold(2);
        scl = 1'b1;
        hold(2);
        r = sda_line;
        hold(2);
    endtask
    // also serves as repeated start
    task automatic go_start();
        scl = 1'b0;
        hold(2);
        sda_rel = 1'b1;
        hold(2);
        scl = 1'b1;
        hold(2);
        sda_rel = 1'b0;
        hold(4);
    endtask
    task automatic go_stop();
        scl = 1'b0;
        hold(2);
        sda_rel = 1'b0;
        hold(2);
        scl = 1'b1;
        hold(2);
        sda_rel = 1'b1;
        hold(4);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~more, r);
    endtask
endmodule
`default_nettype wire

// file: rlcr_regs_bench.sv
`default_nettype none
module rlcr_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rlcr_pkg::*;
    localparam int         DEB   = DEBOUNCE_CYC;
    localparam logic [7:0] ADR_W = 8'h24;
    int         rxc [4] = '{40, 60, 80, 100};
    int         err_count, comparisons, n;
    logic       core_clk, rst_n, scl, sda_rel, sda_out, sda_oe_n, a;
    logic       low_power, lfps, fsm_cm, exit_ok, rxdet, f_ds, f_us, blk, flip;
    logic [1:0] ahi, alo, ctl;
    logic [3:0] ds_st, us_st;
    logic [7:0] d;
    rlcr_gain_t gain;
    wire        sda_line = sda_rel & (sda_oe_n | sda_out);
    rlcr_i2c_ctl rlcr_i2c_ctl_i (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
    rlcr_regs #(.RXDET_CYC_0(23'd40), .RXDET_CYC_1(23'd60),
        .RXDET_CYC_2(23'd80), .RXDET_CYC_3(23'd100)) rlcr_regs_i (
        .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .target_addr_strap_high(ahi), .target_addr_strap_low(alo),
        .downstream_gain_straps(ds_st), .upstream_gain_straps(us_st), .low_power_in(low_power),
        .lfps_in(lfps), .fsm_compliance_in(fsm_cm), .gain_out(gain), .low_power_exit_ok(exit_ok),
        .rxdet_req(rxdet), .compliance_force_ds(f_ds), .compliance_force_us(f_us),
        .compliance_block(blk), .flip_sel(flip), .ctl_sel(ctl));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic final_report();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] q[$]);
        rlcr_i2c_ctl_i.go_start();
        rlcr_i2c_ctl_i.send(ADR_W, a);
        rlcr_i2c_ctl_i.send(ofs, a);
        foreach (q[i]) rlcr_i2c_ctl_i.send(q[i], a);
        rlcr_i2c_ctl_i.go_stop();
    endtask
    task automatic rd_chk(input logic sub, input logic [7:0] ofs, input logic [7:0] exp);
        if (sub) begin
            rlcr_i2c_ctl_i.go_start();
            rlcr_i2c_ctl_i.send(ADR_W, a);
            rlcr_i2c_ctl_i.send(ofs, a);
        end
        rlcr_i2c_ctl_i.go_start();
        rlcr_i2c_ctl_i.send(ADR_W | 8'h01, a);
        rlcr_i2c_ctl_i.recv(1'b0, d);
        rlcr_i2c_ctl_i.go_stop();
        check("register read", {4'h0, d}, {4'h0, exp});
        check("read address ack", {11'h0, a}, 12'h1);
    endtask
    // cycles between two detect pulses
    task automatic gap(output int g);
        int w;
        w = 0;
        while (rxdet !== 1'b1 && w < 300) begin
            @(negedge core_clk);
            w++;
        end
        g = 0;
        do begin
            @(negedge core_clk);
            g++;
        end while (rxdet !== 1'b1 && g < 300);
        if (w >= 300 || g >= 300) begin
            err_count++;
            final_report();
        end
    endtask
    initial begin
        {rst_n, low_power, lfps, fsm_cm, ds_st, us_st} = '0;
        ahi = LVL_FLOAT;
        alo = LVL_FLOAT;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        rlcr_i2c_ctl_i.hold(2);
        rd_chk(1'b1, OFS_LINK_CTL, 8'h04);
        rd_chk(1'b1, OFS_DS_EQ, 8'h00);
        rd_chk(1'b1, OFS_US_EQ, 8'h00);
        rlcr_i2c_ctl_i.go_start();
        rlcr_i2c_ctl_i.send(8'h27, a);
        rlcr_i2c_ctl_i.go_stop();
        check("foreign address ack", {11'h0, a}, 12'h0);
        {ahi, alo} = {LVL_HIGH, LVL_LOW};
        rlcr_i2c_ctl_i.go_start();
        rlcr_i2c_ctl_i.send(ADR_W, a);
        rlcr_i2c_ctl_i.go_stop();
        check("moved address ack", {11'h0, a}, 12'h0);
        {ahi, alo} = {LVL_FLOAT, LVL_FLOAT};
        ds_st = 4'h9;
        us_st = 4'h6;
        rlcr_i2c_ctl_i.hold(3);
        check("strap gain", gain, 12'h996);
        rd_chk(1'b1, OFS_US_EQ, 8'h06);
        reg_wr(OFS_DS_EQ, {8'h5a});
        rd_chk(1'b1, OFS_DS_EQ, 8'h99);
        check("general select reset", {9'h0, flip, ctl}, 12'h001);
        reg_wr(OFS_GENERAL, {8'h3e});
        rd_chk(1'b1, OFS_GENERAL, 8'h16);
        check("general select", {9'h0, flip, ctl}, 12'h006);
        reg_wr(OFS_DS_EQ, {8'ha5, 8'hfc});
        rd_chk(1'b1, OFS_DS_EQ, 8'ha5);
        rd_chk(1'b1, OFS_US_EQ, 8'h0c);
        rd_chk(1'b0, 8'h00, 8'h04);
        check("software gain", gain, 12'ha5c);
        lfps = 1'b1;
        rlcr_i2c_ctl_i.hold(2);
        check("lfps gain forced", gain, 12'h000);
        reg_wr(OFS_LINK_CTL, {8'h44});
        check("lfps gain applied", gain, 12'ha5c);
        low_power = 1'b1;
        rlcr_i2c_ctl_i.hold(3);
        check("exit no debounce", {11'h0, exit_ok}, 12'h1);
        reg_wr(OFS_LINK_CTL, {8'h64});
        lfps = 1'b0;
        rlcr_i2c_ctl_i.hold(2);
        lfps = 1'b1;
        rlcr_i2c_ctl_i.hold(DEB / 2);
        check("exit mid debounce", {11'h0, exit_ok}, 12'h0);
        rlcr_i2c_ctl_i.hold(DEB / 2 + 4);
        check("exit after debounce", {11'h0, exit_ok}, 12'h1);
        for (int c = 0; c < 4; c++) begin
            reg_wr(OFS_LINK_CTL, {{4'h0, c[1:0], 2'h0}});
            gap(n);
            gap(n);
            check("detect interval", 12'(n), 12'(rxc[c]));
        end
        reg_wr(OFS_LINK_CTL, {8'h10});
        n = 0;
        repeat (150) begin
            @(negedge core_clk);
            if (rxdet !== 1'b0) n++;
        end
        check("detect suppressed", 12'(n), 12'h0);
        fsm_cm = 1'b1;
        for (int c = 0; c < 4; c++) begin
            reg_wr(OFS_LINK_CTL, {{6'h20, c[1:0]}});
            rd_chk(1'b1, OFS_LINK_CTL, {c != 3, 5'h0, c[1:0]});
            check("compliance decode", {9'h0, f_ds, f_us, blk}, {9'h0, c == 1, c == 2, c == 3});
        end
        final_report();
    end
endmodule
`default_nettype wire
